// file: hw/dce_pkg.sv
// package: constants and carriers of the character entry port
package dce_pkg;

	// ----------------------------------------
	// sizes and codes
	// ----------------------------------------
	localparam int          DCE_CODE_W    = 6;
	localparam int          DCE_SLOTS     = 8;
	localparam int          DCE_SLOT_W    = 3;
	localparam logic [5:0]  DCE_BLANK     = 6'h20;
	localparam logic [2:0]  DCE_FIRST     = 3'h0;
	localparam logic [3:0]  DCE_PTR_ZERO  = 4'h0;
	localparam logic [3:0]  DCE_PTR_FULL  = 4'h8;
	localparam logic [3:0]  DCE_PTR_STEP  = 4'h1;
	localparam int          DCE_FULL_BIT  = 3;

	// ----------------------------------------
	// latched entry mode
	// ----------------------------------------
	typedef enum logic {
		DCE_DIRECT_SLOT,
		DCE_AUTO_INC
	} dce_mode_t;

	// ----------------------------------------
	// host side pins, sampled together
	// ----------------------------------------
	typedef struct packed {
		logic [5:0] charCodeIn;
		logic       writeStrobeN;
		logic       chipSelect;
		logic       chipSelectN;
		logic       modeIn;
		logic       slotSel0;
		logic       slotSel1;
		logic       slotSel2;
	} dce_host_t;

	// ----------------------------------------
	// display side controls
	// ----------------------------------------
	typedef struct packed {
		logic digitDriveOff;
		logic lampLineDriveOff;
		logic shutdown;
	} dce_disp_t;

endpackage

// file: hw/dce_entry_port.sv
// module: write side of an 8 character display driver
// Summary of operation
// RULE1 - six bit code, high level is one
// RULE2 - write strobe is active low
// RULE3 - strobe and selects ANDed into one
// RULE4 - mode high auto increment, low direct
// RULE5 - mode latched at strobe falling edge
// RULE6 - direct slot address latched at fall
// RULE7 - cascade enable latched at fall
// RULE8 - cascade enable high enables entry
// RULE9 - wipe low clears counter, blanks memory
// RULE10 - full flag high after eight entries
// RULE11 - store at counter then increment
// RULE12 - no store when disabled or full
// RULE13 - mode changes only at falling edge
// RULE14 - host holds wipe high on switch
// RULE15 - full flag driven after rising edge
// RULE16 - data captured at strobe rising edge
// RULE17 - halt pin low gives shutdown
// RULE18 - drives off while entry strobe active
// RULE19 - shutdown blanks, releases full flag
// RULE20 - full stays until wipe clears counter
// RULE21 - strobe synchronised, edges detected
module dce_entry_port #(
	parameter int CODE_W = dce_pkg::DCE_CODE_W,
	parameter int SLOTS  = dce_pkg::DCE_SLOTS
) (
	input  wire logic              clk_sys,
	input  wire logic              reset,
	input  wire dce_pkg::dce_host_t hostPins,
	input  wire logic              memoryWipeN,
	input  wire logic              slotSel2In,
	output logic                   bankFullOut,
	output logic                   bankFullOeN,
	input  wire logic              timebaseHaltPin,
	input  wire logic [2:0]        scanSlot,
	output logic [5:0]             scanCode,
	output dce_pkg::dce_disp_t     dispCtl,
	output dce_pkg::dce_mode_t     entryMode
);
	import dce_pkg::*;

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (CODE_W != DCE_CODE_W) begin : g_code_chk
		$error("code width must be six");
	end
	if (SLOTS != DCE_SLOTS) begin : g_slot_chk
		$error("slot count must be eight");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		dce_host_t                   pin1;
		dce_host_t                   pin2;
		dce_host_t                   pin3;
		logic                        act1;
		logic                        act2;
		logic                        act3;
		dce_mode_t                   mode;
		logic [2:0]                  slot;
		logic                        cascade;
		logic [3:0]                  ptr;
		logic                        fullDrive;
		logic [SLOTS-1:0][5:0]       mem;
		logic [5:0]                  scan;
		dce_disp_t                   disp;
	} dce_state_t;

	dce_state_t st_q;
	dce_state_t st_d;

	logic       actNow;
	logic       fallEdge;
	logic       riseEdge;
	logic       isFull;
	logic       entryOn;
	logic       wipeNow;
	logic       halted;
	dce_host_t  pinNow;

	// ----------------------------------------
	// combined strobe and edges
	// ----------------------------------------
	always_comb begin
		pinNow = hostPins;
		// slot bit two shares the full flag pin
		pinNow.slotSel2 = slotSel2In;
	end

	// one gate so the last input to go active starts it, the first to drop ends it
	assign actNow = !hostPins.writeStrobeN && hostPins.chipSelect
		&& !hostPins.chipSelectN; // RULE2 RULE3

	// edges seen after two flops, never on act1
	assign fallEdge = st_q.act2 && !st_q.act3; // RULE21
	assign riseEdge = !st_q.act2 && st_q.act3; // RULE21

	assign isFull  = st_q.ptr[DCE_FULL_BIT]; // RULE10 RULE20
	assign halted  = !timebaseHaltPin; // RULE17
	assign wipeNow = (st_q.mode == DCE_AUTO_INC) && !memoryWipeN;
	assign entryOn = (st_q.mode == DCE_DIRECT_SLOT)
		|| (st_q.cascade && !isFull); // RULE8 RULE12

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_d      = st_q;
		st_d.pin1 = pinNow;
		st_d.pin2 = st_q.pin1;
		st_d.pin3 = st_q.pin2;
		st_d.act1 = actNow;
		st_d.act2 = st_q.act1;
		st_d.act3 = st_q.act2;

		if (fallEdge) begin
			// mode only ever changes here
			st_d.mode = st_q.pin2.modeIn ? DCE_AUTO_INC
				: DCE_DIRECT_SLOT; // RULE4 RULE5 RULE13
			if (st_q.pin2.modeIn) begin
				st_d.cascade = st_q.pin2.slotSel0; // RULE7
			end else begin
				st_d.slot = {st_q.pin2.slotSel2,
					st_q.pin2.slotSel1,
					st_q.pin2.slotSel0}; // RULE6
				// pin stays an output until this edge
				st_d.fullDrive = 1'b0; // RULE13
			end
		end

		if (riseEdge) begin
			// data sample aligned with last active strobe
			if (st_q.mode == DCE_DIRECT_SLOT) begin
				st_d.mem[st_q.slot] =
					st_q.pin3.charCodeIn; // RULE1 RULE16
			end else begin
				st_d.fullDrive = 1'b1; // RULE15
				if (st_q.cascade && !isFull) begin
					st_d.mem[st_q.ptr[2:0]] =
						st_q.pin3.charCodeIn; // RULE11 RULE16
					st_d.ptr = st_q.ptr
						+ DCE_PTR_STEP; // RULE11
				end
			end
		end

		// wipe wins over a write in the same cycle
		if (wipeNow) begin
			st_d.ptr = DCE_PTR_ZERO; // RULE9 RULE20
			for (int i = 0; i < SLOTS; i++) begin
				st_d.mem[i] = DCE_BLANK; // RULE9
			end
		end

		st_d.scan = st_q.mem[scanSlot];
		st_d.disp.shutdown = halted; // RULE17 RULE19
		st_d.disp.digitDriveOff = halted
			|| (st_q.act2 && entryOn); // RULE18 RULE19
		st_d.disp.lampLineDriveOff = halted
			|| (st_q.act2 && entryOn); // RULE18 RULE19
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_q <= '0;
			st_q.pin1.writeStrobeN <= 1'b1;
			st_q.pin2.writeStrobeN <= 1'b1;
			st_q.pin3.writeStrobeN <= 1'b1;
			st_q.mode <= DCE_DIRECT_SLOT;
			st_q.ptr  <= DCE_PTR_ZERO;
			for (int i = 0; i < SLOTS; i++) begin
				st_q.mem[i] <= DCE_BLANK;
			end
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign bankFullOut = isFull; // RULE10
	// halt releases the pin so a neighbour may drive
	assign bankFullOeN = !(st_q.mode == DCE_AUTO_INC
		&& st_q.fullDrive && !halted); // RULE15 RULE19
	assign scanCode  = st_q.scan;
	assign dispCtl   = st_q.disp;
	assign entryMode = st_q.mode;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_fall;
		!actNow ##1 actNow [*3];
	endsequence

	sequence s_rise;
		st_q.act2 ##1 !st_q.act2;
	endsequence

	mode_latch_a: assert property ( // RULE5
		!st_q.act3 && st_q.act2 |=>
		entryMode == (($past(st_q.pin2.modeIn)) ?
			DCE_AUTO_INC : DCE_DIRECT_SLOT))
		else $error("mode not latched at fall");

	mode_hold_a: assert property ( // RULE13
		!(st_q.act2 && !st_q.act3) |=> $stable(entryMode))
		else $error("mode changed off a fall");

	strobe_sync_a: assert property ( // RULE3
		actNow ##1 actNow ##1 actNow |=> st_q.act2)
		else $error("combined strobe not seen");

	ptr_step_a: assert property ( // RULE11
		riseEdge && entryMode == DCE_AUTO_INC && st_q.cascade
		&& !isFull && memoryWipeN
		|=> st_q.ptr == $past(st_q.ptr) + DCE_PTR_STEP)
		else $error("counter did not advance");

	ptr_block_a: assert property ( // RULE12
		entryMode == DCE_AUTO_INC && (isFull || !st_q.cascade)
		&& memoryWipeN |=> $stable(st_q.ptr) && $stable(st_q.mem))
		else $error("entry taken while blocked");

	full_sticky_a: assert property ( // RULE20
		isFull && !wipeNow |=> isFull)
		else $error("full flag dropped without wipe");

	wipe_clear_a: assert property ( // RULE9
		wipeNow |=> st_q.ptr == DCE_PTR_ZERO
		&& st_q.mem[DCE_FIRST] == DCE_BLANK)
		else $error("wipe did not clear");

	direct_write_a: assert property ( // RULE16
		riseEdge && entryMode == DCE_DIRECT_SLOT
		|=> st_q.mem[$past(st_q.slot)] == $past(st_q.pin3.charCodeIn))
		else $error("direct write lost");

	full_drive_a: assert property ( // RULE15
		s_rise ##0 (entryMode == DCE_AUTO_INC && !halted)
		##1 !halted |-> !bankFullOeN)
		else $error("full flag not driven");

	drive_off_a: assert property ( // RULE18
		st_q.act2 && entryOn |=> dispCtl.digitDriveOff
		&& dispCtl.lampLineDriveOff)
		else $error("drives on during entry");

	halt_off_a: assert property ( // RULE19
		halted |=> dispCtl.shutdown)
		else $error("shutdown not applied");

	halt_release_a: assert property ( // RULE19
		halted |-> bankFullOeN)
		else $error("full pin driven in shutdown");

	cascade_latch_a: assert property ( // RULE7
		fallEdge && st_q.pin2.modeIn
		|=> st_q.cascade == $past(st_q.pin2.slotSel0))
		else $error("cascade enable not latched");

	slot_latch_a: assert property ( // RULE6
		fallEdge && !st_q.pin2.modeIn
		|=> st_q.slot == {$past(st_q.pin2.slotSel2),
			$past(st_q.pin2.slotSel1),
			$past(st_q.pin2.slotSel0)})
		else $error("slot select not latched");

	slot_hold_a: assert property ( // RULE6
		!fallEdge |=> $stable(st_q.slot))
		else $error("slot select moved off a fall");

	auto_write_a: assert property ( // RULE11
		riseEdge && entryMode == DCE_AUTO_INC && st_q.cascade
		&& !isFull && memoryWipeN
		|=> st_q.mem[$past(st_q.ptr[2:0])]
			== $past(st_q.pin3.charCodeIn))
		else $error("auto entry not stored");

	wipe_all_a: assert property ( // RULE9
		wipeNow |=> st_q.mem == {SLOTS{DCE_BLANK}})
		else $error("wipe left a code behind");

	drive_on_a: assert property ( // RULE18
		!st_q.act2 && !halted |=> !dispCtl.digitDriveOff
		&& !dispCtl.lampLineDriveOff)
		else $error("drives off while idle");

	halt_keep_a: assert property ( // RULE17
		halted && !riseEdge && !wipeNow |=> $stable(st_q.mem))
		else $error("memory lost in shutdown");

	fall_seen_a: assert property ( // RULE21
		s_fall |-> fallEdge)
		else $error("fall not detected");

endmodule // dce_entry_port

// file: dv/dce_host_model.sv
// host side model: drives strobe cycles into the entry port
module dce_host_model (
	output dce_pkg::dce_host_t pins,
	input  wire logic          clk_sys
);
	timeunit 1ns;
	timeprecision 1ps;
	import dce_pkg::*;
	// ----------------------------------------
	// idle bus, strobe and wipe cycles
	// ----------------------------------------
	initial pins = 13'h0E02;
	task automatic strobe(input logic m, input logic [2:0] a,
		input logic [5:0] c, input logic useCs);
		@(negedge clk_sys);
		pins.modeIn = m;
		{pins.slotSel2, pins.slotSel1, pins.slotSel0} = a;
		pins.charCodeIn = c;
		pins.writeStrobeN = !useCs;
		pins.chipSelect = !useCs;
		pins.chipSelectN = 1'b0;
		@(negedge clk_sys);
		if (useCs) pins.chipSelect = 1'b1;
		else pins.writeStrobeN = 1'b0;
		repeat (4) @(negedge clk_sys);
		// address is latched by now, so a shared bus may move on
		if (!m) {pins.slotSel2, pins.slotSel1, pins.slotSel0} = ~a;
		repeat (3) @(negedge clk_sys);
		// a direct write may end on the low active select instead
		if (useCs) pins.chipSelect = 1'b0;
		else if (!m) pins.chipSelectN = 1'b1;
		else pins.writeStrobeN = 1'b1;
		repeat (4) @(negedge clk_sys);
		pins.charCodeIn = ~c; // released bus does not hold
	endtask
	task automatic wipe;
		@(negedge clk_sys);
		pins.slotSel1 = 1'b0;
		repeat (4) @(negedge clk_sys);
		pins.slotSel1 = 1'b1;
		repeat (2) @(negedge clk_sys);
	endtask
endmodule // dce_host_model

// file: dv/display_char_entry_port_tb.sv
// testbench of the character entry port
module display_char_entry_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dce_pkg::*;
	// ----------------------------------------
	// harness
	// ----------------------------------------
	logic       clk_sys = 1'b0;
	logic       reset = 1'b1;
	logic       haltPin = 1'b1;
	logic [2:0] scanSlot = 3'h0;
	dce_host_t  hostPins;
	logic       fullOut, fullOeN, a2Wire;
	logic [5:0] scanCode;
	dce_disp_t  dispCtl;
	dce_mode_t  entryMode;
	int         failures = 0;
	int         samples_checked = 0;
	always #2 clk_sys = ~clk_sys;
	// shared pin: device drives it while its enable is low
	assign a2Wire = fullOeN ? hostPins.slotSel2 : fullOut;
	dce_host_model host (.pins(hostPins), .clk_sys(clk_sys));
	dce_entry_port dut (.clk_sys(clk_sys), .reset(reset),
		.hostPins(hostPins), .memoryWipeN(hostPins.slotSel1),
		.slotSel2In(a2Wire), .bankFullOut(fullOut),
		.bankFullOeN(fullOeN), .timebaseHaltPin(haltPin),
		.scanSlot(scanSlot), .scanCode(scanCode),
		.dispCtl(dispCtl), .entryMode(entryMode));
	task automatic tally_and_finish;
		if (failures == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1) begin
			failures++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask
	task automatic rd(input logic [2:0] s, input logic [5:0] e);
		@(negedge clk_sys);
		scanSlot = s;
		repeat (2) @(negedge clk_sys);
		chk(scanCode === e, "stored code");
	endtask
	task automatic put(input logic m, input logic [2:0] a,
		input logic [5:0] c, input logic cs, input logic off);
		fork
			host.strobe(m, a, c, cs);
			begin
				repeat (6) @(negedge clk_sys);
				chk(dispCtl.digitDriveOff === off, "digit off");
				chk(dispCtl.lampLineDriveOff === off, "lamp off");
			end
		join
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		for (int i = 0; i < 8; i++) rd(i[2:0], DCE_BLANK);
		chk(entryMode === DCE_DIRECT_SLOT, "mode");
		chk(fullOeN === 1'b1, "pin released");
	endtask
	task automatic t_direct;
		// odd slots strobe through the high select
		for (int i = 0; i < 8; i++) put(1'b0, i[2:0], 6'h15 ^ i[5:0], i[0], 1'b1);
		for (int i = 0; i < 8; i++) rd(i[2:0], 6'h15 ^ i[5:0]);
		chk(entryMode === DCE_DIRECT_SLOT, "direct mode");
	endtask
	task automatic t_auto;
		for (int i = 0; i < 8; i++) begin
			put(1'b1, 3'h3, 6'h30 + i[5:0], 1'b0, 1'b1);
			chk(fullOeN === 1'b0, "full pin driven");
			chk(a2Wire === (i == 7), "full flag");
		end
		chk(entryMode === DCE_AUTO_INC, "auto mode");
		put(1'b1, 3'h3, 6'h3F, 1'b0, 1'b0);
		for (int i = 0; i < 8; i++) rd(i[2:0], 6'h30 + i[5:0]);
		chk(fullOut === 1'b1, "full held");
		host.wipe();
		chk(fullOut === 1'b0, "wipe clears full");
		for (int i = 0; i < 8; i++) rd(i[2:0], DCE_BLANK);
		put(1'b1, 3'h2, 6'h11, 1'b0, 1'b0);
		rd(3'h0, DCE_BLANK);
		put(1'b1, 3'h3, 6'h12, 1'b1, 1'b1);
		rd(3'h0, 6'h12);
		rd(3'h1, DCE_BLANK);
	endtask
	task automatic t_halt;
		haltPin = 1'b0;
		repeat (3) @(negedge clk_sys);
		chk(dispCtl.shutdown === 1'b1, "shutdown");
		chk(fullOeN === 1'b1, "full released");
		chk(dispCtl.digitDriveOff === 1'b1, "digit off halted");
		chk(dispCtl.lampLineDriveOff === 1'b1, "lamp off halted");
		rd(3'h0, 6'h12);
		haltPin = 1'b1;
		repeat (3) @(negedge clk_sys);
		chk(dispCtl.shutdown === 1'b0, "awake");
	endtask
	task automatic t_back;
		// slot two keeps the shared pin low while it still drives
		put(1'b0, 3'h2, 6'h2A, 1'b0, 1'b1);
		chk(entryMode === DCE_DIRECT_SLOT, "back to direct");
		chk(fullOeN === 1'b1, "pin back to host");
		rd(3'h2, 6'h2A);
		fork
			host.strobe(1'b1, 3'h3, 6'h2B, 1'b0);
			begin
				repeat (6) @(negedge clk_sys);
				chk(fullOeN === 1'b1, "pin idle before rise");
			end
		join
		chk(fullOeN === 1'b0, "pin driven after rise");
		rd(3'h1, 6'h2B);
	endtask
	initial begin
		repeat (4) @(negedge clk_sys);
		reset = 1'b0;
		t_reset();
		t_direct();
		t_auto();
		t_halt();
		t_back();
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		tally_and_finish();
	end
endmodule // display_char_entry_port_tb
